// ---- adcr_map.vh ----
// Purpose: Register offsets, field positions, reset values and timing for the converter control.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Offsets are local choices; fields sit in the low byte.
`ifndef ADCR_MAP_VH
`define ADCR_MAP_VH

`define ADCR_OFS_STATUS_CONTROL 12'h000
`define ADCR_OFS_RESULT_HIGH 12'h004
`define ADCR_OFS_RESULT_LOW 12'h008
`define ADCR_OFS_CLOCK_CONFIG 12'h00C

// Status and control fields.
`define ADCR_SC_CH_LSB 0
`define ADCR_SC_CH_MSB 4
`define ADCR_SC_CONT_BIT 5
`define ADCR_SC_CONVERSION_COMPLETE_FLAG_BIT 7
`define ADCR_CH_OFF 5'h1F

// Clock configuration fields.
`define ADCR_CK_ASYNC_CLOCK_ENABLE_BIT 0
`define ADCR_CK_ICLK_BIT 1
`define ADCR_CK_MODE_LSB 2
`define ADCR_CK_MODE_MSB 3
`define ADCR_CK_LSMP_BIT 4
`define ADCR_CK_DIV_LSB 5
`define ADCR_CK_DIV_MSB 6
`define ADCR_CK_LPC_BIT 7

`define ADCR_CLOCK_CONFIG_RST 8'h00
`define ADCR_SC_RST 8'h1F

`define ADCR_MODE_8BIT 2'h0
`define ADCR_MODE_10BIT_SW 2'h1
`define ADCR_MODE_RSVD 2'h2
`define ADCR_MODE_10BIT_HW 2'h3

// Sample phase in half converter clocks: 3.5 and 23.5 cycles.
`define ADCR_SAMPLE_SHORT_HALF 8'h07
`define ADCR_SAMPLE_LONG_HALF 8'h2F
// Successive approximation steps, one per converter clock.
`define ADCR_SAR_STEPS 8'h0A

`endif

// ---- adcr_clkdiv.v ----
// Purpose: Converter clock enable from the selected input clock enable.
// Assumes: Input enable is a one-cycle pulse on pclk.
// Notes: Produces one pulse every 1, 2, 4 or 8 input pulses.
`timescale 1ns/1ns
`include "adcr_map.vh"

module adcr_clkdiv (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire run,
  input wire in_en,
  input wire [1:0] div_sel,
  // Output
  output reg converter_clock_en
);

  reg [2:0] cnt_r;
  reg [2:0] last;

  always @* begin
    case (div_sel)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      default: last = 3'h7;
    endcase
  end

  // The counter restarts when idle so a conversion started from idle sees whole converter periods.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      converter_clock_en <= 1'b0;
    end else if (!run) begin
      cnt_r <= 3'h0;
      converter_clock_en <= 1'b0;
    end else if (in_en) begin
      converter_clock_en <= (cnt_r == last);
      cnt_r <= (cnt_r == last) ? 3'h0 : cnt_r + 3'h1;
    end else begin
      converter_clock_en <= 1'b0;
    end
  end

endmodule

// ---- adcr_core.v ----
// Purpose: Result registers, interlock and clock configuration of a 10-bit converter.
// Assumes: APB slave, zero wait states; analog sample arrives on sar_value.
// Notes: The analog core is outside; this block sequences it and holds results.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "adcr_map.vh"

// Function
// - Each finished conversion not locked out loads both result registers.
// - High holds MSBs; unused high bits read zero.
// - Reading high locks results until low read.
// - Conversions finishing while locked are discarded.
// - Eight-bit mode has no interlock.
// - Unused channels give undefined results.
// - Low-power bit selects reduced-power slower operation.
// - Divider codes divide by 1, 2, 4, 8.
// - Clock select picks bus or alternate clock.
// - Mode field selects 8, 10, hardware-trigger.
// - Reset gives 8-bit software-triggered mode.
// - Result rounded to resolution, not truncated.
// - Sample phase 23.5 or 3.5 converter clocks; the code samples for 24 or 4.
// - Async clock used, runs only converting, stop ok.
// - Without async clock, stop mode ends conversions.
// - Complete flag cleared by low read, control write.
// - Control write aborts and restarts unless channel off.
module adcr_core (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Clock sources and system state
  input wire alt_clk_en,
  input wire async_clk_en,
  input wire stop_mode,
  input wire hw_trigger,
  // Analog core
  input wire [11:0] sar_value,
  input wire voltage_inhibit_power_down,
  output reg sar_sample,
  output reg sar_power,
  output reg low_power_config,
  output reg async_clock_run,
  output reg [4:0] channel_select
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg [7:0] clock_config_r;
  reg [7:0] sc_r;
  reg [7:0] result_high_r;
  reg [7:0] result_low_r;
  reg locked_r;
  reg [1:0] state_r;
  reg [7:0] phase_cnt_r;
  reg half_r;
  reg [2:0] bus_div_r;
  reg bus_en_r;

  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr_sc = acc && pwrite && (paddr == `ADCR_OFS_STATUS_CONTROL);
  wire wr_ck = acc && pwrite && (paddr == `ADCR_OFS_CLOCK_CONFIG);
  wire rd_hi = acc && !pwrite && (paddr == `ADCR_OFS_RESULT_HIGH);
  wire rd_lo = acc && !pwrite && (paddr == `ADCR_OFS_RESULT_LOW);

  wire async_on = clock_config_r[`ADCR_CK_ASYNC_CLOCK_ENABLE_BIT];
  wire [1:0] mode = clock_config_r[`ADCR_CK_MODE_MSB:`ADCR_CK_MODE_LSB];
  wire ten_bit = mode[0];
  wire [4:0] ch = sc_r[`ADCR_SC_CH_MSB:`ADCR_SC_CH_LSB];
  wire cont = sc_r[`ADCR_SC_CONT_BIT];
  wire in_en;
  wire converter_clock_en;
  wire run = (state_r != ST_IDLE);

  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a == `ADCR_OFS_STATUS_CONTROL) || (a == `ADCR_OFS_RESULT_HIGH) ||
                   (a == `ADCR_OFS_RESULT_LOW) || (a == `ADCR_OFS_CLOCK_CONFIG);
    end
  endfunction

  // The bus clock is used at a quarter of pclk as the internal bus-clock source.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_div_r <= 3'h0;
      bus_en_r <= 1'b0;
    end else begin
      bus_div_r <= bus_div_r + 3'h1;
      bus_en_r <= (bus_div_r[1:0] == 2'h3);
    end
  end

  // Async source wins; otherwise the select bit picks bus or alternate clock.
  assign in_en = async_on ? async_clk_en :
                 (clock_config_r[`ADCR_CK_ICLK_BIT] ? bus_en_r : alt_clk_en);

  adcr_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .in_en(in_en),
    .div_sel(clock_config_r[`ADCR_CK_DIV_MSB:`ADCR_CK_DIV_LSB]),
    .converter_clock_en(converter_clock_en)
  );

  // Rounding to the chosen width: 12 raw bits carry two guard bits beyond ten.
  reg [10:0] r10;
  reg [8:0] r8;
  reg [9:0] res;
  always @* begin
    r10 = {1'b0, sar_value[11:2]} + {10'h000, sar_value[1]};
    r8 = {1'b0, sar_value[11:4]} + {8'h00, sar_value[3]};
    if (ten_bit) begin
      res = r10[10] ? 10'h3FF : r10[9:0];
    end else begin
      res = r8[8] ? 10'h0FF : {2'h0, r8[7:0]};
    end
  end

  // Start conditions: software write, hardware trigger in mode 11, or continuous rerun.
  wire ch_on = (ch != `ADCR_CH_OFF);
  wire sw_start = wr_sc && (pwdata[`ADCR_SC_CH_MSB:`ADCR_SC_CH_LSB] != `ADCR_CH_OFF);
  wire hw_start = (mode == `ADCR_MODE_10BIT_HW) && hw_trigger && ch_on && !run;
  wire stop_kill = stop_mode && !async_on;
  wire [7:0] sample_len = clock_config_r[`ADCR_CK_LSMP_BIT] ?
                          `ADCR_SAMPLE_LONG_HALF : `ADCR_SAMPLE_SHORT_HALF;
  wire done = (state_r == ST_CONVERT) && converter_clock_en && (phase_cnt_r == 8'h01);
  // Modes 00 and 01 start by software only; the reserved code behaves as 00.
  wire sw_mode = (mode != `ADCR_MODE_10BIT_HW);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      phase_cnt_r <= 8'h00;
      half_r <= 1'b0;
    end else if (stop_kill || wr_ck) begin
      state_r <= ST_IDLE;
      phase_cnt_r <= 8'h00;
      half_r <= 1'b0;
    end else if (wr_sc) begin
      // Abort the running conversion; start again unless the channel is off.
      state_r <= sw_start ? ST_SAMPLE : ST_IDLE;
      phase_cnt_r <= sample_len;
      half_r <= 1'b0;
    end else if (hw_start) begin
      state_r <= ST_SAMPLE;
      phase_cnt_r <= sample_len;
      half_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          phase_cnt_r <= 8'h00;
        end
        // Sampling counts half periods, two per converter clock; an odd count ends on a whole clock, giving 4 or 24 clocks.
        ST_SAMPLE: begin
          if (converter_clock_en) begin
            if (phase_cnt_r <= 8'h02) begin
              state_r <= ST_CONVERT;
              phase_cnt_r <= `ADCR_SAR_STEPS;
              half_r <= phase_cnt_r[0];
            end else begin
              phase_cnt_r <= phase_cnt_r - 8'h02;
            end
          end
        end
        ST_CONVERT: begin
          if (converter_clock_en) begin
            if (phase_cnt_r == 8'h01) begin
              state_r <= (cont && ch_on && sw_mode) ? ST_SAMPLE : ST_IDLE;
              phase_cnt_r <= sample_len;
            end else begin
              phase_cnt_r <= phase_cnt_r - 8'h01;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Result registers and the read interlock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_r <= 8'h00;
      result_low_r <= 8'h00;
      locked_r <= 1'b0;
    end else begin
      if (done && !(locked_r && ten_bit)) begin
        result_high_r <= {6'h00, res[9:8]};
        result_low_r <= res[7:0];
      end
      if (rd_lo) begin
        locked_r <= 1'b0;
      end else if (rd_hi && ten_bit) begin
        locked_r <= 1'b1;
      end else if (!ten_bit) begin
        locked_r <= 1'b0;
      end
    end
  end

  // Control registers; the complete flag sets on done, which wins over a clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_config_r <= `ADCR_CLOCK_CONFIG_RST;
      sc_r <= `ADCR_SC_RST;
    end else begin
      if (wr_ck) begin
        clock_config_r <= pwdata[7:0];
      end
      if (wr_sc) begin
        sc_r[6:0] <= pwdata[6:0];
      end
      if (done) begin
        sc_r[`ADCR_SC_CONVERSION_COMPLETE_FLAG_BIT] <= 1'b1;
      end else if (wr_sc || rd_lo) begin
        sc_r[`ADCR_SC_CONVERSION_COMPLETE_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Read data is registered in the setup cycle, so every access has no wait state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !known_addr(paddr);
      if (setup && !pwrite) begin
        case (paddr)
          `ADCR_OFS_STATUS_CONTROL: prdata <= {24'h000000, sc_r};
          `ADCR_OFS_RESULT_HIGH: prdata <= {24'h000000, result_high_r};
          `ADCR_OFS_RESULT_LOW: prdata <= {24'h000000, result_low_r};
          `ADCR_OFS_CLOCK_CONFIG: prdata <= {24'h000000, clock_config_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Analog-side controls. Channel codes beyond the valid set are passed through unchecked.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_sample <= 1'b0;
      sar_power <= 1'b0;
      low_power_config <= 1'b0;
      async_clock_run <= 1'b0;
      channel_select <= 5'h1F;
    end else begin
      sar_sample <= (state_r == ST_SAMPLE);
      sar_power <= run && ch_on;
      low_power_config <= clock_config_r[`ADCR_CK_LPC_BIT];
      async_clock_run <= async_on && run;
      channel_select <= ch;
    end
  end

endmodule

// ---- adcr_chk.sv ----
// Purpose: Port assertions for the converter control block.
// Assumes: Zero-wait APB and the shared register map.
// Notes: Clock configuration is shadowed from bus writes.
`timescale 1ns/1ns
`include "adcr_map.vh"
module adcr_chk (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Converter side
  input wire stop_mode,
  input wire sar_sample,
  input wire sar_power,
  input wire low_power_config,
  input wire async_clock_run,
  input wire [4:0] channel_select
);
  reg [7:0] cfg_r;
  wire wr_ck = pready && pwrite && paddr == `ADCR_OFS_CLOCK_CONFIG;
  wire wr_sc = pready && pwrite && paddr == `ADCR_OFS_STATUS_CONTROL;
  wire mapped = paddr[1:0] == 2'h0 && paddr <= `ADCR_OFS_CLOCK_CONFIG;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_r <= 8'h00;
    else if (wr_ck)
      cfg_r <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready without access");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("wrong error response");
  a_high_zero: assert property (pready && !pwrite && paddr == `ADCR_OFS_RESULT_HIGH
    |-> prdata[31:2] == 30'h0)
    else $error("unused high bits set");
  a_lpc_copy: assert property (wr_ck |=> ##1 low_power_config == $past(pwdata[7], 2))
    else $error("low power output stale");
  a_chan_copy: assert property (wr_sc |=> ##1 channel_select == $past(pwdata[4:0], 2))
    else $error("channel output stale");
  a_off_idle: assert property ((channel_select == `ADCR_CH_OFF) [*2] |-> !sar_power)
    else $error("powered with channel off");
  a_sample_pwr: assert property (sar_sample |-> sar_power)
    else $error("sampling while unpowered");
  a_async_run: assert property (async_clock_run |-> cfg_r[0] || $past(cfg_r[0]))
    else $error("async clock runs while disabled");
  a_stop_halt: assert property ((stop_mode && !cfg_r[0]) [*3] |-> !sar_power)
    else $error("conversion runs in stop");
endmodule
bind adcr_core adcr_chk chk (.*);

// ---- test_adc_result_and_clock_config.sv ----
// Purpose: Self-checking bench for the converter control block.
// Assumes: Zero-wait APB; bus tick is pclk/4.
// Notes: Conversion time is checked in a window, as divider phase is free.
`timescale 1ns/1ns
`include "adcr_map.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin n_fail = n_fail + 1; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_adc_result_and_clock_config;
  localparam [11:0] o_sc = `ADCR_OFS_STATUS_CONTROL;
  localparam [11:0] o_hi = `ADCR_OFS_RESULT_HIGH;
  localparam [11:0] o_lo = `ADCR_OFS_RESULT_LOW;
  localparam [11:0] o_ck = `ADCR_OFS_CLOCK_CONFIG;
  reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg alt_clk_en = 1'h0, async_clk_en = 1'h0, stop_mode = 1'h0, hw_trigger = 1'h0, er;
  reg [11:0] paddr = 12'h000, sar_value = 12'h000;
  reg [31:0] pwdata = 32'h0, rd, seed = 32'h00001E18;
  reg [7:0] v;
  wire voltage_inhibit_power_down = 1'h0;
  wire [31:0] prdata;
  wire pready, pslverr, sar_sample, sar_power, low_power_config, async_clock_run;
  wire [4:0] channel_select;
  integer n_fail = 0, checks = 0, i, m, n, eh, el;
  time t0;
  adcr_core dut (.*);
  always #2 pclk = ~pclk;
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  always @(posedge pclk) begin
    seed <= xs(seed);
    alt_clk_en <= seed[3];
    async_clk_en <= seed[9];
  end
  task tally_and_finish;
    begin
      if (n_fail == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Ready is read right after each rising edge, which is the value that edge sampled.
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready !== 1'h1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (k >= 20) begin
        n_fail = n_fail + 1;
        tally_and_finish;
      end
    end
  endtask
  task rdc(input [11:0] a, input [31:0] x);
    begin
      apb(1'h0, a, 32'h0);
      `CHK(rd, x)
    end
  endtask
  task poll;
    begin
      rd = 32'h0;
      for (n = 0; n < 1000 && rd[7] !== 1'h1; n = n + 1)
        apb(1'h0, o_sc, 32'h0);
      if (n >= 1000) begin
        n_fail = n_fail + 1;
        tally_and_finish;
      end
    end
  endtask
  task conv;
    begin
      sar_value <= seed[13:2];
      t0 = $time;
      apb(1'h1, o_sc, 32'h0);
      poll;
      m = ($time - t0) / 4;
    end
  endtask
  // Rounded half up and saturated, as the converter output is 12 bits wide.
  task res(input m10);
    begin
      el = m10 ? (sar_value + 2) / 4 : (sar_value + 8) / 16;
      if (el > (m10 ? 1023 : 255))
        el = m10 ? 1023 : 255;
      rdc(o_hi, el / 256);
      rdc(o_lo, el % 256);
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rdc(o_ck, 32'h0);
    rdc(o_sc, 32'h1F);
    apb(1'h0, 12'h010, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    for (i = 0; i < 4; i = i + 1) begin
      v = seed[7:0];
      apb(1'h1, o_ck, v);
      rdc(o_ck, v);
      `CHK(low_power_config, v[7])
    end
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'h1, o_ck, i * 32 + i % 2 * 16 + 2);
      apb(1'h0, o_hi, 32'h0);
      conv;
      n = ((i % 2) * 20 + 14) * 4 << i;
      `CHK(m > n - 8 && m < n + (8 << i) + 24, 1'h1)
      res(1'h0);
    end
    apb(1'h1, o_ck, 32'h06);
    conv;
    res(1'h1);
    conv;
    conv;
    eh = (sar_value + 2) / 4;
    if (eh > 1023)
      eh = 1023;
    apb(1'h0, o_hi, 32'h0);
    conv;
    rdc(o_lo, eh % 256);
    rdc(o_sc, 32'h0);
    conv;
    res(1'h1);
    apb(1'h1, o_ck, 32'h04);
    conv;
    res(1'h1);
    apb(1'h1, o_ck, 32'h05);
    stop_mode <= 1'h1;
    conv;
    stop_mode <= 1'h0;
    res(1'h1);
    apb(1'h1, o_ck, 32'h04);
    apb(1'h1, o_sc, 32'h0);
    stop_mode <= 1'h1;
    repeat (300) @(posedge pclk);
    stop_mode <= 1'h0;
    rdc(o_sc, 32'h0);
    apb(1'h1, o_ck, 32'h0E);
    sar_value <= seed[13:2];
    hw_trigger <= 1'h1;
    poll;
    hw_trigger <= 1'h0;
    res(1'h1);
    apb(1'h1, o_sc, 32'h1F);
    rdc(o_sc, 32'h1F);
    tally_and_finish;
  end
endmodule
